// ===== process_image_assembler.sv
// cyclic 50-byte input image assembler toward the fieldbus master
// Function
// - image is 50 bytes in five consecutive 10-byte blocks
// - default bytes 0 and 1 carry main inputs 1-16, lowest in bit 0
// - default byte 2 carries main inputs 17-20 in bits 3..0
// - default byte 3 carries main four output values in bits 3..0
// - direct bytes pass unchanged; defaults bytes 4-11 hold direct 0-7
// - only direct bytes 0-23 can be mapped, to any of the 50 positions
// - default bytes 12-23 carry module 1-12 input bytes in order
// - default bytes 24-35 carry module output bytes; masks per module type
// - third data set layout is fixed, not configurable
// - up to four bytes of collective state may be placed in image
// - configuration may move or replace preassigned value bytes
// - input and output state words: main, modules, gateways, reserved
// - state bit 0 means error, 1 means no error
// - image goes out as five blocks of ten byte positions
// - unassigned positions are sent as zero
// - in operational state the image is sent each cycle whose edge finds no frame in progress
`timescale 1ns/100ps
`default_nettype none
module process_image_assembler
	import image_pkg::*;
#(
	parameter int N_BYTES = IMG_BYTES,
	parameter int N_MOD   = MOD_COUNT,
	parameter int DEPTH   = FIFO_DEPTH
) (
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic                  cycle_strobe,
	input  wire logic                  bus_operational,
	input  wire logic [19:0]           main_inputs,
	input  wire logic [3:0]            main_outputs,
	input  wire logic [8*N_MOD-1:0]    mod_inputs,
	input  wire logic [8*N_MOD-1:0]    mod_outputs,
	input  wire logic [N_MOD-1:0]      mod_has_outputs,
	input  wire logic [N_MOD-1:0]      mod_four_outputs,
	input  wire logic [N_MOD:0]        in_ok,
	input  wire logic [N_MOD:0]        out_ok,
	input  wire logic [1:0]            gw_in_ok,
	input  wire logic [1:0]            gw_out_ok,
	input  wire logic [8*N_BYTES-1:0]  direct_bytes,
	input  wire logic                  custom_map,
	input  wire logic [6*N_BYTES-1:0]  byte_src_map,
	output logic [15:0]                in_state_word,
	output logic [15:0]                out_state_word,
	output logic [7:0]                 tx_data,
	output logic                       tx_valid,
	output logic                       tx_first,
	output logic                       tx_last,
	input  wire logic                  tx_ready,
	output logic                       frame_busy,
	output logic                       cycle_overrun
);
	initial begin
		if (N_BYTES != BLK_BYTES * BLK_COUNT || N_MOD != MOD_COUNT)
			$error("image geometry unsupported");
		if (DEPTH < N_BYTES / 2)
			$error("fifo too shallow");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_DONE = 3'b100
	} send_state_t;

	// two-flop synchronisers for the external cycle and state inputs
	logic [1:0] cyc_sync_reg;
	logic [1:0] op_sync_reg;
	logic       cyc_prev_reg;
	logic       cyc_pulse;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cyc_sync_reg <= 2'b00;
			op_sync_reg  <= 2'b00;
			cyc_prev_reg <= 1'b0;
		end else begin
			cyc_sync_reg <= {cyc_sync_reg[0], cycle_strobe};
			op_sync_reg  <= {op_sync_reg[0], bus_operational};
			cyc_prev_reg <= cyc_sync_reg[1];
		end
	end
	assign cyc_pulse = cyc_sync_reg[1] && !cyc_prev_reg;

	// state words: main, modules, gateways, reserved low
	logic [15:0] in_state_next;
	logic [15:0] out_state_next;
	always_comb begin
		in_state_next                            = 16'h0000;
		out_state_next                           = 16'h0000;
		in_state_next[ST_MAIN_BIT]               = in_ok[0];
		out_state_next[ST_MAIN_BIT]              = out_ok[0];
		in_state_next[ST_MOD_LSB +: MOD_COUNT]   = in_ok[MOD_COUNT:1];
		out_state_next[ST_MOD_LSB +: MOD_COUNT]  = out_ok[MOD_COUNT:1];
		in_state_next[ST_GW_LSB +: 2]            = gw_in_ok;
		out_state_next[ST_GW_LSB +: 2]           = gw_out_ok;
		in_state_next[ST_RSVD_BIT]               = 1'b0;
		out_state_next[ST_RSVD_BIT]              = 1'b0;
	end

	function automatic logic [5:0] default_src(input int pos);
		if (pos == POS_MAIN_IN_LO)
			return SRC_MAIN_LO;
		else if (pos == POS_MAIN_IN_HI)
			return SRC_MAIN_HI;
		else if (pos == POS_MAIN_IN_X)
			return SRC_MAIN_X;
		else if (pos == POS_MAIN_OUT)
			return SRC_MAIN_OUT;
		else if (pos >= POS_DIRECT && pos < POS_DIRECT + DIRECT_DEFAULT)
			return 6'(SRC_DIRECT + 6'(pos - POS_DIRECT));
		else if (pos >= POS_MOD_IN && pos < POS_MOD_IN + MOD_COUNT)
			return 6'(SRC_MOD_IN + 6'(pos - POS_MOD_IN));
		else if (pos >= POS_MOD_OUT && pos < POS_MOD_OUT + MOD_COUNT)
			return 6'(SRC_MOD_OUT + 6'(pos - POS_MOD_OUT));
		else
			return SRC_NONE;
	endfunction : default_src

	// one byte from a source code; unknown codes give zero
	function automatic logic [7:0] pick(input logic [5:0] src,
		input logic [15:0] ist, input logic [15:0] ost);
		int k;
		k = 0;
		if (src == SRC_MAIN_LO)
			return main_inputs[7:0];
		else if (src == SRC_MAIN_HI)
			return main_inputs[15:8];
		else if (src == SRC_MAIN_X)
			return {4'h0, main_inputs[19:16]};
		else if (src == SRC_MAIN_OUT)
			return {4'h0, main_outputs};
		else if (src == SRC_IN_ST_LO)
			return ist[7:0];
		else if (src == SRC_IN_ST_HI)
			return ist[15:8];
		else if (src == SRC_OUT_ST_LO)
			return ost[7:0];
		else if (src == SRC_OUT_ST_HI)
			return ost[15:8];
		else if (src >= SRC_MOD_IN && src < SRC_MOD_IN + 6'(MOD_COUNT)) begin
			k = int'(src - SRC_MOD_IN);
			return mod_inputs[8*k +: 8];
		end else if (src >= SRC_MOD_OUT && src < SRC_MOD_OUT + 6'(MOD_COUNT)) begin
			k = int'(src - SRC_MOD_OUT);
			if (!mod_has_outputs[k])
				return BYTE_ZERO;
			else if (mod_four_outputs[k])
				return mod_outputs[8*k +: 8] & NIBBLE_MASK;
			else
				return mod_outputs[8*k +: 8];
		end else if (src >= SRC_DIRECT) begin
			// six-bit codes reach direct bytes 0 to 23 only
			k = int'(src - SRC_DIRECT);
			return direct_bytes[8*k +: 8];
		end else
			return BYTE_ZERO;
	endfunction : pick

	logic [7:0] image_next [N_BYTES];
	always_comb begin
		for (int i = 0; i < N_BYTES; i++) begin
			if (custom_map)
				image_next[i] = pick(byte_src_map[6*i +: 6],
					in_state_next, out_state_next);
			else
				image_next[i] = pick(default_src(i),
					in_state_next, out_state_next);
		end
	end

	// snapshot of the whole image on the cycle edge
	logic [7:0]  image_reg [N_BYTES];
	send_state_t state_reg;
	logic [5:0]  idx_reg;
	logic        take;
	assign take = cyc_pulse && state_reg == ST_IDLE;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < N_BYTES; i++)
				image_reg[i] <= BYTE_ZERO;
			in_state_word  <= 16'h0000;
			out_state_word <= 16'h0000;
		end else if (take) begin
			for (int i = 0; i < N_BYTES; i++)
				image_reg[i] <= op_sync_reg[1] ? image_next[i] : BYTE_ZERO;
			in_state_word  <= in_state_next;
			out_state_word <= out_state_next;
		end
	end

	byte_stream_if bs ();
	logic fifo_wr_ok;
	assign fifo_wr_ok = bs.valid && bs.ready;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			idx_reg   <= 6'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (take) begin
						state_reg <= ST_SEND;
						idx_reg   <= 6'h00;
					end
				end
				ST_SEND: begin
					if (fifo_wr_ok) begin
						if (idx_reg == 6'(N_BYTES - 1))
							state_reg <= ST_DONE;
						else
							idx_reg <= idx_reg + 6'h01;
					end
				end
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			cycle_overrun <= 1'b0;
		else
			cycle_overrun <= cyc_pulse && state_reg != ST_IDLE;
	end

	assign bs.data  = image_reg[idx_reg];
	assign bs.valid = state_reg == ST_SEND;
	assign bs.last  = idx_reg == 6'(N_BYTES - 1);
	assign frame_busy = state_reg != ST_IDLE;

	// independent byte count per frame for the length check
	logic [5:0] byte_cnt_reg;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			byte_cnt_reg <= 6'h00;
		else if (take)
			byte_cnt_reg <= 6'h00;
		else if (fifo_wr_ok)
			byte_cnt_reg <= byte_cnt_reg + 6'h01;
	end

	logic [8:0] rd_word;
	logic       first_reg;
	image_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
		.core_clk (core_clk),
		.rstn     (rstn),
		.wr_data  ({bs.last, bs.data}),
		.wr_valid (bs.valid),
		.wr_ready (bs.ready),
		.rd_data  (rd_word),
		.rd_valid (tx_valid),
		.rd_ready (tx_ready)
	);
	assign tx_data = rd_word[7:0];
	assign tx_last = rd_word[8];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			first_reg <= 1'b1;
		else if (tx_valid && tx_ready)
			first_reg <= rd_word[8];
	end
	assign tx_first = first_reg && tx_valid;

	sequence frame_start_s;
		take;
	endsequence
	sequence frame_run_s;
		##1 state_reg == ST_SEND;
	endsequence
	sequence frame_close_s;
		##1 state_reg == ST_IDLE && !frame_busy;
	endsequence
	frame_starts_a: assert property (@(posedge core_clk) disable iff (!rstn)
		frame_start_s |-> frame_run_s)
		else $error("frame did not start");
	hold_image_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_SEND && !take) |=> $stable(image_reg[0]) && $stable(image_reg[49]))
		else $error("image changed mid frame");
	zero_unused_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map) |=> image_reg[40] == BYTE_ZERO && image_reg[36] == BYTE_ZERO)
		else $error("unassigned byte not zero");
	main_nibble_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map) |=> image_reg[2][7:4] == 4'h0 && image_reg[3][7:4] == 4'h0)
		else $error("main upper nibble set");
	main_low_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[0] == $past(main_inputs[7:0]))
		else $error("byte zero mismatch");
	direct_pass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[4] == $past(direct_bytes[7:0]))
		else $error("direct byte changed");
	mod_in_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[12] == $past(mod_inputs[7:0]))
		else $error("module input byte wrong");
	state_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn)
		take |=> !in_state_word[15] && in_state_word[0] == $past(in_ok[0]))
		else $error("state word wrong");
	frame_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_SEND && fifo_wr_ok && bs.last) |=> state_reg == ST_DONE)
		else $error("frame length wrong");
	frame_bytes_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_DONE) |-> byte_cnt_reg == 6'(N_BYTES))
		else $error("frame byte count wrong");
	frame_close_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_DONE) |-> frame_close_s)
		else $error("frame did not close");
	tx_order_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(tx_valid && tx_first) |-> !tx_last)
		else $error("first and last together");
	main_hi_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[1] == $past(main_inputs[15:8]))
		else $error("byte one mismatch");
	main_x_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[2][3:0] == $past(main_inputs[19:16]))
		else $error("byte two mismatch");
	main_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && op_sync_reg[1]) |=> image_reg[3] == {4'h0, $past(main_outputs)})
		else $error("byte three mismatch");
	mod_mask_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && mod_four_outputs[0]) |=> image_reg[24][7:4] == 4'h0)
		else $error("module output mask wrong");
	mod_none_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !custom_map && !mod_has_outputs[1]) |=> image_reg[25] == BYTE_ZERO)
		else $error("input-only module byte not zero");
	idle_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && !op_sync_reg[1]) |=> image_reg[0] == BYTE_ZERO && image_reg[12] == BYTE_ZERO)
		else $error("image not zero while not operational");
	state_fixed_a: assert property (@(posedge core_clk) disable iff (!rstn)
		take |=> !out_state_word[ST_RSVD_BIT] && out_state_word[ST_MAIN_BIT] == $past(out_ok[0]))
		else $error("output state word wrong");
	overrun_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(cyc_pulse && state_reg != ST_IDLE) |=> cycle_overrun && $stable(image_reg[0]))
		else $error("refused cycle edge not flagged");
	direct_far_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && custom_map && op_sync_reg[1] && byte_src_map[60 +: 6] == 6'h3f)
		|=> image_reg[10] == $past(direct_bytes[191:184]))
		else $error("direct byte 23 wrong");
	map_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(take && custom_map && byte_src_map[30 +: 6] == SRC_NONE) |=> image_reg[5] == BYTE_ZERO)
		else $error("unmapped byte not zero");
endmodule : process_image_assembler
`default_nettype wire

// ===== image_pkg.sv
// constants for the process image assembler
package image_pkg;
	localparam int IMG_BYTES      = 50;
	localparam int BLK_BYTES      = 10;
	localparam int BLK_COUNT      = 5;
	localparam int MOD_COUNT      = 12;
	localparam int DIRECT_DEFAULT = 8;
	localparam int STATE_BYTES    = 4;
	localparam int FIFO_DEPTH     = 32;
	localparam int SEL_W          = 6;
	// byte positions of the default allocation
	localparam int POS_MAIN_IN_LO = 0;
	localparam int POS_MAIN_IN_HI = 1;
	localparam int POS_MAIN_IN_X  = 2;
	localparam int POS_MAIN_OUT   = 3;
	localparam int POS_DIRECT     = 4;
	localparam int POS_MOD_IN     = 12;
	localparam int POS_MOD_OUT    = 24;
	// state word fields
	localparam int ST_MAIN_BIT    = 0;
	localparam int ST_MOD_LSB     = 1;
	localparam int ST_GW_LSB      = 13;
	localparam int ST_RSVD_BIT    = 15;
	// source selector encoding
	localparam logic [5:0] SRC_NONE     = 6'h00;
	localparam logic [5:0] SRC_MAIN_LO  = 6'h01;
	localparam logic [5:0] SRC_MAIN_HI  = 6'h02;
	localparam logic [5:0] SRC_MAIN_X   = 6'h03;
	localparam logic [5:0] SRC_MAIN_OUT = 6'h04;
	localparam logic [5:0] SRC_IN_ST_LO = 6'h05;
	localparam logic [5:0] SRC_IN_ST_HI = 6'h06;
	localparam logic [5:0] SRC_OUT_ST_LO = 6'h07;
	localparam logic [5:0] SRC_OUT_ST_HI = 6'h08;
	localparam logic [5:0] SRC_MOD_IN   = 6'h10;
	localparam logic [5:0] SRC_MOD_OUT  = 6'h1c;
	localparam logic [5:0] SRC_DIRECT   = 6'h28;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [7:0] NIBBLE_MASK  = 8'h0f;
endpackage : image_pkg

// ===== byte_stream_if.sv
// valid/ready byte stream between assembler and fifo
`timescale 1ns/100ps
`default_nettype none
interface byte_stream_if;
	logic [7:0] data;
	logic       valid;
	logic       ready;
	logic       last;
	modport src (output data, output valid, output last, input ready);
	modport dst (input data, input valid, input last, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ===== image_fifo.sv
// parameterised first-in first-out buffer
`timescale 1ns/100ps
`default_nettype none
module image_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	output logic      [WIDTH-1:0] rd_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;
	assign full     = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty    = wr_ptr_reg == rd_ptr_reg;
	assign wr_ready = !full;
	assign rd_valid = !empty;
	assign rd_data  = mem[rd_ptr_reg[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (wr_valid && !full)
			mem[wr_ptr_reg[AW-1:0]] <= wr_data;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			wr_ptr_reg <= '0;
		else if (wr_valid && !full)
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rd_ptr_reg <= '0;
		else if (rd_ready && !empty)
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
	end
	no_overflow_a: assert property (@(posedge core_clk) disable iff (!rstn)
		full |-> ##1 !(wr_ptr_reg != $past(wr_ptr_reg) && empty))
		else $error("fifo overflow");
endmodule : image_fifo
`default_nettype wire

// ===== image_master_model.sv
// fieldbus master model draining the image byte stream
`timescale 1ns/100ps
`default_nettype none
module image_master_model (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [7:0]   tx_data,
	input  wire logic         tx_valid,
	input  wire logic         tx_first,
	input  wire logic         tx_last,
	input  wire logic         slow,
	output logic              tx_ready,
	output logic [399:0]      frame_flat,
	output logic [15:0]       frame_cnt,
	output logic [15:0]       framing_err
);
	logic [5:0] idx_reg;
	logic [2:0] div_reg;
	// slow mode takes one byte in eight
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			div_reg <= 3'h0;
		else
			div_reg <= div_reg + 3'h1;
	end
	assign tx_ready = rstn && (!slow || div_reg == 3'h0);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			idx_reg <= 6'h00;
			frame_cnt <= 16'h0000;
			framing_err <= 16'h0000;
			frame_flat <= '0;
		end else if (tx_valid && tx_ready) begin
			frame_flat[8*idx_reg +: 8] <= tx_data;
			if ((tx_first !== (idx_reg == 6'h00)) || (tx_last !== (idx_reg == 6'h31))) begin
				framing_err <= framing_err + 16'h0001;
			end
			if (idx_reg == 6'h31) begin
				idx_reg <= 6'h00;
				frame_cnt <= frame_cnt + 16'h0001;
			end else
				idx_reg <= idx_reg + 6'h01;
		end
	end
endmodule : image_master_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the process image assembler
`timescale 1ns/100ps
`default_nettype none
module tb
	import image_pkg::*;
;
	typedef struct packed {
		logic [19:0] mi;
		logic [3:0]  mo;
		logic [7:0]  mb;
		logic [7:0]  db;
		logic [11:0] has;
		logic [11:0] four;
		logic [12:0] iok;
		logic [12:0] ook;
		logic [1:0]  gi;
		logic [1:0]  go;
		logic [15:0] ist;
		logic [15:0] ost;
	} row_t;
	row_t rows [4] = '{
		'{20'ha_5c3f, 4'h9, 8'h10, 8'h80, 12'hfff, 12'h0f0, 13'h1fff, 13'h1fff, 2'h3, 2'h3,
			16'h7fff, 16'h7fff},
		'{20'h5_a3c0, 4'h6, 8'hf0, 8'h01, 12'h0db, 12'h0db, 13'h0001, 13'h1ffe, 2'h1, 2'h2,
			16'h2001, 16'h5ffe},
		'{20'hf_ffff, 4'hf, 8'hff, 8'hff, 12'h000, 12'h000, 13'h0000, 13'h0000, 2'h0, 2'h0,
			16'h0000, 16'h0000},
		'{20'h0_0000, 4'h0, 8'h00, 8'h00, 12'hfff, 12'h000, 13'h1555, 13'h0aaa, 2'h2, 2'h1,
			16'h5555, 16'h2aaa}
	};
	logic         core_clk = 1'b0;
	logic         rstn, cycle_strobe, bus_operational, custom_map, tx_ready, slow;
	logic [19:0]  main_inputs;
	logic [3:0]   main_outputs;
	logic [95:0]  mod_inputs, mod_outputs;
	logic [11:0]  mod_has_outputs, mod_four_outputs;
	logic [12:0]  in_ok, out_ok;
	logic [1:0]   gw_in_ok, gw_out_ok;
	logic [399:0] direct_bytes, frame_flat;
	logic [299:0] byte_src_map, map_v;
	logic [15:0]  in_state_word, out_state_word, frame_cnt, framing_err, n;
	logic [7:0]   tx_data;
	logic         tx_valid, tx_first, tx_last, frame_busy, cycle_overrun;
	logic [7:0]   exp_img [50];
	int           error_cnt = 0, compares = 0, ovr_cnt = 0;

	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) if (cycle_overrun === 1'b1) ovr_cnt++;

	process_image_assembler process_image_assembler_i (.core_clk(core_clk), .rstn(rstn),
		.cycle_strobe(cycle_strobe), .bus_operational(bus_operational),
		.main_inputs(main_inputs), .main_outputs(main_outputs), .mod_inputs(mod_inputs),
		.mod_outputs(mod_outputs), .mod_has_outputs(mod_has_outputs),
		.mod_four_outputs(mod_four_outputs), .in_ok(in_ok), .out_ok(out_ok),
		.gw_in_ok(gw_in_ok), .gw_out_ok(gw_out_ok), .direct_bytes(direct_bytes),
		.custom_map(custom_map), .byte_src_map(byte_src_map), .in_state_word(in_state_word),
		.out_state_word(out_state_word), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
		.frame_busy(frame_busy), .cycle_overrun(cycle_overrun));
	image_master_model image_master_model_i (.core_clk(core_clk), .rstn(rstn),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last),
		.slow(slow), .tx_ready(tx_ready), .frame_flat(frame_flat), .frame_cnt(frame_cnt),
		.framing_err(framing_err));

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic conclude();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic apply(input row_t r);
		@(posedge core_clk);
		main_inputs <= r.mi;
		main_outputs <= r.mo;
		mod_has_outputs <= r.has;
		mod_four_outputs <= r.four;
		in_ok <= r.iok;
		out_ok <= r.ook;
		gw_in_ok <= r.gi;
		gw_out_ok <= r.go;
		for (int k = 0; k < 12; k++) begin
			mod_inputs[8*k +: 8] <= r.mb + 8'(k);
			mod_outputs[8*k +: 8] <= r.mb ^ (8'h33 + 8'(k));
		end
		for (int k = 0; k < 50; k++) direct_bytes[8*k +: 8] <= r.db + 8'(k);
	endtask : apply

	// expected image for the default allocation
	task automatic build_exp();
		logic [7:0] m;
		@(negedge core_clk);
		foreach (exp_img[i]) exp_img[i] = 8'h00;
		exp_img[0] = main_inputs[7:0];
		exp_img[1] = main_inputs[15:8];
		exp_img[2] = {4'h0, main_inputs[19:16]};
		exp_img[3] = {4'h0, main_outputs};
		for (int k = 0; k < 8; k++) exp_img[4+k] = direct_bytes[8*k +: 8];
		for (int k = 0; k < 12; k++) begin
			exp_img[12+k] = mod_inputs[8*k +: 8];
			m = mod_four_outputs[k] ? 8'h0f : 8'hff;
			exp_img[24+k] = mod_has_outputs[k] ? (mod_outputs[8*k +: 8] & m) : 8'h00;
		end
	endtask : build_exp

	task automatic strobe();
		@(posedge core_clk);
		cycle_strobe <= 1'b1;
		repeat (3) @(posedge core_clk);
		cycle_strobe <= 1'b0;
	endtask : strobe

	task automatic wait_frame(input logic [15:0] t);
		int w;
		w = 0;
		while (frame_cnt !== t && w < 2000) begin
			@(negedge core_clk);
			w++;
		end
		check("frame count", frame_cnt, t);
		for (int i = 0; i < 50; i++) begin
			check("image byte", {8'h00, frame_flat[8*i +: 8]}, {8'h00, exp_img[i]});
		end
		check("framing", framing_err, 16'h0000);
	endtask : wait_frame

	task automatic frame(input string nm);
		n = frame_cnt;
		strobe();
		wait_frame(n + 16'h0001);
		$display("test %s done", nm);
	endtask : frame

	task automatic check_reset();
		@(negedge core_clk);
		check("valid in reset", {15'h0000, tx_valid}, 16'h0000);
		check("busy in reset", {15'h0000, frame_busy}, 16'h0000);
		check("state in reset", in_state_word, 16'h0000);
		$display("test reset done");
	endtask : check_reset

	initial begin
		rstn = 1'b0;
		cycle_strobe = 1'b0;
		bus_operational = 1'b1;
		custom_map = 1'b0;
		slow = 1'b0;
		byte_src_map = '0;
		apply(rows[0]);
		repeat (11) @(posedge core_clk);
		check_reset();
		@(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		foreach (rows[j]) begin
			apply(rows[j]);
			build_exp();
			frame("default map");
			check("in state", in_state_word, rows[j].ist);
			check("out state", out_state_word, rows[j].ost);
		end
		@(posedge core_clk);
		bus_operational <= 1'b0;
		repeat (4) @(posedge core_clk);
		foreach (exp_img[i]) exp_img[i] = 8'h00;
		frame("bus not operational");
		// relocated bytes, state bytes and an unused code
		map_v = '0;
		map_v[0 +: 6] = SRC_IN_ST_LO;
		map_v[6 +: 6] = SRC_IN_ST_HI;
		map_v[12 +: 6] = SRC_OUT_ST_LO;
		map_v[18 +: 6] = SRC_OUT_ST_HI;
		map_v[60 +: 6] = 6'h3f;
		map_v[120 +: 6] = 6'h1b;
		map_v[126 +: 6] = SRC_MOD_OUT;
		map_v[132 +: 6] = SRC_MAIN_X;
		map_v[138 +: 6] = SRC_MAIN_OUT;
		map_v[144 +: 6] = SRC_MAIN_HI;
		map_v[180 +: 6] = 6'h09;
		map_v[294 +: 6] = SRC_MAIN_LO;
		@(posedge core_clk);
		bus_operational <= 1'b1;
		custom_map <= 1'b1;
		byte_src_map <= map_v;
		main_inputs <= 20'h3_c5a7;
		main_outputs <= 4'hb;
		repeat (4) @(posedge core_clk);
		foreach (exp_img[i]) exp_img[i] = 8'h00;
		exp_img[0] = 8'h55;
		exp_img[1] = 8'h55;
		exp_img[2] = 8'haa;
		exp_img[3] = 8'h2a;
		exp_img[10] = 8'h17;
		exp_img[20] = 8'h0b;
		exp_img[21] = 8'h33;
		exp_img[22] = 8'h03;
		exp_img[23] = 8'h0b;
		exp_img[24] = 8'hc5;
		exp_img[49] = 8'ha7;
		frame("custom map");
		check("fixed state", in_state_word, rows[3].ist);
		@(posedge core_clk);
		custom_map <= 1'b0;
		slow <= 1'b1;
		build_exp();
		n = frame_cnt;
		strobe();
		repeat (6) @(posedge core_clk);
		main_inputs <= 20'hf_0f0f;
		direct_bytes <= '1;
		strobe();
		@(negedge core_clk);
		check("busy while stalled", {15'h0000, frame_busy}, 16'h0001);
		wait_frame(n + 16'h0001);
		repeat (300) @(posedge core_clk);
		@(negedge core_clk);
		check("single frame", frame_cnt, n + 16'h0001);
		check("overrun pulses", 16'(ovr_cnt), 16'h0001);
		$display("test stall and overrun done");
		@(posedge core_clk);
		slow <= 1'b0;
		strobe();
		repeat (10) @(posedge core_clk);
		rstn <= 1'b0;
		check_reset();
		@(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		build_exp();
		frame("reset mid frame");
		conclude();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		$display("mismatch watchdog expected finish seen timeout");
		conclude();
	end
endmodule : tb
`default_nettype wire
